//--- shared/tccu_pkg.sv
/*
  Package of the timer capture/compare unit: register offsets, field
  positions, reset values, mode encodings and timing counts.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.
*/
package tccu_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ALT_PIN   = 8'h00;
  localparam logic [7:0] OFS_CONTROL   = 8'h04;
  localparam logic [7:0] OFS_CC_LOW    = 8'h08;
  localparam logic [7:0] OFS_CC_HIGH   = 8'h0C;
  localparam logic [7:0] OFS_INT_EN    = 8'h10;
  localparam logic [7:0] OFS_INT_FLAGS = 8'h14;
  localparam logic [7:0] OFS_TMR_CTRL  = 8'h18;
  localparam logic [7:0] OFS_TMR_LOW   = 8'h1C;
  localparam logic [7:0] OFS_TMR_HIGH  = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PIN_LOC_BIT   = 0;
  localparam int UNIT_FLAG_BIT = 2;
  localparam int UNIT_EN_BIT   = 2;
  localparam int TMR_ON_BIT    = 0;
  localparam int TMR_SRC_LSB   = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // unit mode field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_CMP_TOG  = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4TH  = 4'h6;
  localparam logic [3:0] MODE_CAP_16TH = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SWI  = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEV = 4'hB;

  // ----------------------------------------------------------------
  // shared timer clock sources
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_INSTR = 2'h0;
  localparam logic [1:0] SRC_SYS   = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int INSTR_DIV     = 4;
  localparam int PRESC_4       = 4;
  localparam int PRESC_16      = 16;

  function automatic logic is_capture(input logic [3:0] mode);
    return mode[3:2] == 2'h1;
  endfunction

  function automatic logic is_compare(input logic [3:0] mode);
    return (mode == MODE_CMP_TOG) || (mode[3:2] == 2'h2);
  endfunction

  function automatic logic drives_pin(input logic [3:0] mode);
    return (mode == MODE_CMP_TOG) || (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLR);
  endfunction

endpackage

//--- core/tccu_pin_sync.sv
/*
  Two-flop synchroniser with rising and falling edge pulses.
  Assumes an asynchronous level on pin_in; pulses are one clock wide.
*/
`timescale 1ns/1ps
`default_nettype none
module tccu_pin_sync
  import tccu_pkg::*;
(
  // clock and reset
  input  wire logic clock_in,
  input  wire logic srst_in,
  // pin side
  input  wire logic pin_in,
  // synchronised side
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges judged only past the second flop
  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule
`default_nettype wire

//--- core/tccu_prescaler.sv
/*
  Capture edge prescaler: one event every 4th or 16th qualifying edge.
  Assumes edge_in is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tccu_prescaler
  import tccu_pkg::*;
#(
  parameter int CNT_W = 4
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic srst_in,
  // control
  input  wire logic hold_clear_in,
  input  wire logic div16_in,
  input  wire logic edge_in,
  // result
  output logic      event_out
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             wrap;

  always_comb begin
    wrap  = div16_in ? (cnt_q == CNT_W'(PRESC_16 - 1)) : (cnt_q == CNT_W'(PRESC_4 - 1));
    cnt_d = cnt_q;
    if (hold_clear_in) begin
      cnt_d = '0;
    end else if (edge_in) begin
      cnt_d = wrap ? '0 : cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign event_out = edge_in & wrap & ~hold_clear_in;
endmodule
`default_nettype wire

//--- core/tccu_top.sv
/*
  Timer capture/compare unit with its shared 16-bit timer and APB
  register slave. Assumes pins arrive asynchronously, sleep_in comes
  from same-clock logic, and pin direction bits live outside.
*/
// Contract
// - Four capture prescaler settings chosen by the mode field.
// - Prescaler counter held at zero when off or not capturing.
// - Prescaler counter cleared on every reset.
// - Switching between capture settings keeps the prescaler count.
// - Instruction-clocked timer halts in sleep and resumes its value.
// - Captures continue in sleep with an external timer clock.
// - Bit 0 of alternate pin select relocates the unit pin.
// - Compare mode continuously compares register pair with timer.
// - Match toggles, sets, clears output, triggers event, or interrupts.
// - Every compare match sets unit flag bit 2 with the action.
// - Capture copies the timer into the pair and sets the flag.
// - Capture on falling, rising, every 4th or 16th rising edge.
// - New capture overwrites the pair; flag stays until cleared.
// - Edge detector watches the pin level itself.
`timescale 1ns/1ps
`default_nettype none
module tccu_top
  import tccu_pkg::*;
#(
  parameter int TMR_W = 16
) (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // system
  input  wire logic        sleep_in,
  input  wire logic        ext_tmr_clk_in,
  // unit pin, primary and alternate locations
  input  wire logic        pin_main_in,
  output logic             pin_main_out,
  output logic             pin_main_oe_out,
  input  wire logic        pin_alt_in,
  output logic             pin_alt_out,
  output logic             pin_alt_oe_out,
  // events
  output logic             unit_irq_out,
  output logic             special_trigger_out
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]       alt_pin_q,  alt_pin_d;
  logic [7:0]       control_q,  control_d;
  logic [TMR_W-1:0] cc_q,       cc_d;
  logic [7:0]       int_en_q,   int_en_d;
  logic             flag_q,     flag_d;
  logic [7:0]       tmr_ctrl_q, tmr_ctrl_d;
  logic [TMR_W-1:0] tmr_q,      tmr_d;
  logic [1:0]       div_q,      div_d;
  logic             out_latch_q, out_latch_d;
  logic             match_q,    match_d;
  logic             spev_pend_q, spev_pend_d;
  logic [31:0]      prdata_q,   prdata_d;

  logic [3:0] mode;
  logic       wr_en;
  logic       setup;
  logic       mapped;
  logic       tmr_on;
  logic [1:0] tmr_src;
  logic       tmr_tick;
  logic       main_rise;
  logic       main_fall;
  logic       alt_rise;
  logic       alt_fall;
  logic       cap_rise;
  logic       cap_fall;
  logic       ext_rise;
  logic       presc_event;
  logic       cap_event;
  logic       match_now;
  logic       match_event;

  assign mode    = control_q[3:0];
  assign tmr_on  = tmr_ctrl_q[TMR_ON_BIT];
  assign tmr_src = tmr_ctrl_q[TMR_SRC_LSB +: 2];

  // ----------------------------------------------------------------
  // pin location and synchronisers
  // ----------------------------------------------------------------
  // raw pad levels feed the detectors, so port writes can capture;
  // each location has its own flops, so a location switch never
  // lets an unsynchronised level reach the edge logic
  tccu_pin_sync u_main_sync (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .pin_in    (pin_main_in),
    .level_out (),
    .rise_out  (main_rise),
    .fall_out  (main_fall)
  );

  tccu_pin_sync u_alt_sync (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .pin_in    (pin_alt_in),
    .level_out (),
    .rise_out  (alt_rise),
    .fall_out  (alt_fall)
  );

  assign cap_rise = alt_pin_q[PIN_LOC_BIT] ? alt_rise : main_rise;
  assign cap_fall = alt_pin_q[PIN_LOC_BIT] ? alt_fall : main_fall;

  tccu_pin_sync u_ext_sync (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .pin_in    (ext_tmr_clk_in),
    .level_out (),
    .rise_out  (ext_rise),
    .fall_out  ()
  );

  // ----------------------------------------------------------------
  // capture event qualification
  // ----------------------------------------------------------------
  tccu_prescaler u_presc (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .hold_clear_in (~is_capture(mode)),
    .div16_in      (mode == MODE_CAP_16TH),
    .edge_in       (cap_rise & ((mode == MODE_CAP_4TH) | (mode == MODE_CAP_16TH))),
    .event_out     (presc_event)
  );

  always_comb begin
    case (mode)
      MODE_CAP_FALL: cap_event = cap_fall;
      MODE_CAP_RISE: cap_event = cap_rise;
      MODE_CAP_4TH:  cap_event = presc_event;
      MODE_CAP_16TH: cap_event = presc_event;
      default:       cap_event = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // shared timer tick
  // ----------------------------------------------------------------
  always_comb begin
    div_d    = div_q;
    tmr_tick = 1'b0;
    case (tmr_src)
      SRC_INSTR: begin
        // divider frozen in sleep so the count resumes unchanged
        if (tmr_on && !sleep_in) begin
          div_d    = (div_q == 2'(INSTR_DIV - 1)) ? 2'h0 : div_q + 2'h1;
          tmr_tick = (div_q == 2'(INSTR_DIV - 1));
        end
      end
      SRC_SYS:  tmr_tick = tmr_on & ~sleep_in;
      SRC_EXT:  tmr_tick = tmr_on & ext_rise;
      default:  tmr_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // compare
  // ----------------------------------------------------------------
  // only a fresh equality counts, so a stopped timer fires once
  assign match_now   = is_compare(mode) && (tmr_q == cc_q);
  assign match_event = match_now & ~match_q;

  always_comb begin
    match_d     = match_now;
    out_latch_d = out_latch_q;
    spev_pend_d = spev_pend_q & match_now; // moving the pair cancels the reset
    if (mode == MODE_OFF) begin
      out_latch_d = 1'b0;
    end else if (match_event) begin
      case (mode)
        MODE_CMP_TOG:  out_latch_d = ~out_latch_q;
        MODE_CMP_SET:  out_latch_d = 1'b1;
        MODE_CMP_CLR:  out_latch_d = 1'b0;
        MODE_CMP_SPEV: spev_pend_d = 1'b1;
        default:       out_latch_d = out_latch_q;
      endcase
    end
  end

  assign special_trigger_out = match_event & (mode == MODE_CMP_SPEV);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    case (paddr)
      OFS_ALT_PIN, OFS_CONTROL, OFS_CC_LOW, OFS_CC_HIGH, OFS_INT_EN,
      OFS_INT_FLAGS, OFS_TMR_CTRL, OFS_TMR_LOW, OFS_TMR_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    prdata_d = prdata_q;
    if (setup) begin
      case (paddr)
        OFS_ALT_PIN:   prdata_d = {24'h000000, alt_pin_q};
        OFS_CONTROL:   prdata_d = {24'h000000, control_q};
        OFS_CC_LOW:    prdata_d = {24'h000000, cc_q[7:0]};
        OFS_CC_HIGH:   prdata_d = {24'h000000, cc_q[15:8]};
        OFS_INT_EN:    prdata_d = {24'h000000, int_en_q};
        OFS_INT_FLAGS: prdata_d = {29'h00000000, flag_q, 2'h0};
        OFS_TMR_CTRL:  prdata_d = {24'h000000, tmr_ctrl_q};
        OFS_TMR_LOW:   prdata_d = {24'h000000, tmr_q[7:0]};
        OFS_TMR_HIGH:  prdata_d = {24'h000000, tmr_q[15:8]};
        default:       prdata_d = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    alt_pin_d  = alt_pin_q;
    control_d  = control_q;
    cc_d       = cc_q;
    int_en_d   = int_en_q;
    flag_d     = flag_q;
    tmr_ctrl_d = tmr_ctrl_q;
    tmr_d      = tmr_q;
    if (wr_en) begin
      case (paddr)
        OFS_ALT_PIN:   alt_pin_d  = pwdata[7:0];
        OFS_CONTROL:   control_d  = pwdata[7:0];
        OFS_CC_LOW:    cc_d[7:0]  = pwdata[7:0];
        OFS_CC_HIGH:   cc_d[15:8] = pwdata[7:0];
        OFS_INT_EN:    int_en_d   = pwdata[7:0];
        OFS_INT_FLAGS: flag_d     = pwdata[UNIT_FLAG_BIT];
        OFS_TMR_CTRL:  tmr_ctrl_d = pwdata[7:0];
        OFS_TMR_LOW:   tmr_d[7:0]  = pwdata[7:0];
        OFS_TMR_HIGH:  tmr_d[15:8] = pwdata[7:0];
        default:       alt_pin_d  = alt_pin_q;
      endcase
    end
    // a software write to the timer wins over its own count
    if (!(wr_en && (paddr == OFS_TMR_LOW || paddr == OFS_TMR_HIGH)) && tmr_tick) begin
      tmr_d = spev_pend_q ? RST_WORD : tmr_q + TMR_W'(1);
    end
    // hardware capture wins over a software write to the pair
    if (cap_event) begin
      cc_d = tmr_q;
    end
    // set wins over a clear in the same cycle
    if (cap_event || match_event) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      alt_pin_q   <= RST_BYTE;
      control_q   <= RST_BYTE;
      cc_q        <= RST_WORD;
      int_en_q    <= RST_BYTE;
      flag_q      <= 1'b0;
      tmr_ctrl_q  <= RST_BYTE;
      tmr_q       <= RST_WORD;
      div_q       <= 2'h0;
      out_latch_q <= 1'b0;
      match_q     <= 1'b0;
      spev_pend_q <= 1'b0;
      prdata_q    <= 32'h00000000;
    end else begin
      alt_pin_q   <= alt_pin_d;
      control_q   <= control_d;
      cc_q        <= cc_d;
      int_en_q    <= int_en_d;
      flag_q      <= flag_d;
      tmr_ctrl_q  <= tmr_ctrl_d;
      tmr_q       <= tmr_d;
      div_q       <= div_d;
      out_latch_q <= out_latch_d;
      match_q     <= match_d;
      spev_pend_q <= spev_pend_d;
      prdata_q    <= prdata_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata          = prdata_q;
  assign unit_irq_out    = flag_q & int_en_q[UNIT_EN_BIT];
  assign pin_main_out    = out_latch_q;
  assign pin_alt_out     = out_latch_q;
  assign pin_main_oe_out = drives_pin(mode) & ~alt_pin_q[PIN_LOC_BIT];
  assign pin_alt_oe_out  = drives_pin(mode) & alt_pin_q[PIN_LOC_BIT];
endmodule
`default_nettype wire

//--- bench/tccu_asserts.sv
/*
  Port checker of the capture/compare unit.
  Assumes a bind to tccu_top; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module tccu_asserts
  import tccu_pkg::*;
#(
  parameter int TMR_W = 16
) (
  // clock and reset
  input wire logic        clock_in,
  input wire logic        srst_in,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // system and pins
  input wire logic        sleep_in,
  input wire logic        ext_tmr_clk_in,
  input wire logic        pin_main_in,
  input wire logic        pin_main_out,
  input wire logic        pin_main_oe_out,
  input wire logic        pin_alt_in,
  input wire logic        pin_alt_out,
  input wire logic        pin_alt_oe_out,
  // events
  input wire logic        unit_irq_out,
  input wire logic        special_trigger_out
);
  // --
  // shadow of the enable bit
  // --
  logic      en_q;
  logic      en_d;
  wire logic acc_wr;
  wire logic mapped;
  assign acc_wr = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_TMR_HIGH);
  always_comb begin
    en_d = en_q;
    if (acc_wr && paddr == OFS_INT_EN) begin
      en_d = pwdata[UNIT_EN_BIT];
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      en_q <= 1'b0;
    end else begin
      en_q <= en_d;
    end
  end
  // --
  // properties
  // --
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_slverr_map: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr does not match address");
  chk_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_oe_single: assert property (!(pin_main_oe_out && pin_alt_oe_out))
    else $error("both pin locations driven");
  chk_trig_pulse: assert property (special_trigger_out |=> !special_trigger_out)
    else $error("trigger longer than one cycle");
  chk_trig_nopin: assert property (special_trigger_out |-> !pin_main_oe_out)
    else $error("trigger mode drives pin");
  chk_flag_action: assert property (pin_main_oe_out && $past(pin_main_oe_out)
    && $changed(pin_main_out) && en_q |-> unit_irq_out)
    else $error("match action without flag");
  chk_flag_hold: assert property (unit_irq_out && !(acc_wr && (paddr == OFS_INT_FLAGS
    || paddr == OFS_INT_EN)) |=> unit_irq_out)
    else $error("flag dropped without software");
  chk_irq_mask: assert property (!en_q |-> !unit_irq_out)
    else $error("interrupt while masked");
endmodule
`default_nettype wire

//--- bench/tccu_pin_model.sv
/*
  External source for the unit pins and the external timer clock.
  Assumes calls from one process; pin idles low, clock stands still.
*/
`timescale 1ns/1ps
`default_nettype none
module tccu_pin_model (
  // clock
  input  wire logic clock_in,
  // far side levels
  output logic      main_out,
  output logic      alt_out,
  output logic      ext_clk_out
);
  initial begin
    main_out = 1'b0;
    alt_out = 1'b0;
    ext_clk_out = 1'b0;
  end
  // each level held long enough for the synchroniser and capture
  task automatic level(input logic alt, input logic v);
    @(posedge clock_in);
    if (alt) alt_out <= v;
    else main_out <= v;
    repeat (5) @(posedge clock_in);
  endtask
  task automatic pulses(input logic alt, input int n);
    for (int i = 0; i < n; i++) begin
      level(alt, 1'b1);
      level(alt, 1'b0);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock_in);
      ext_clk_out <= 1'b1;
      repeat (4) @(posedge clock_in);
      ext_clk_out <= 1'b0;
      repeat (4) @(posedge clock_in);
    end
  endtask
endmodule
`default_nettype wire

//--- bench/tccu_tb_top.sv
/*
  Register-level testbench of the capture/compare unit.
  Assumes tccu_top, the pin model and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module tccu_tb_top;
  import tccu_pkg::*;
  localparam int TMR_W = 16;
  localparam logic [7:0] OFS [9] = '{OFS_ALT_PIN, OFS_CONTROL, OFS_CC_LOW, OFS_CC_HIGH,
    OFS_INT_EN, OFS_INT_FLAGS, OFS_TMR_CTRL, OFS_TMR_LOW, OFS_TMR_HIGH};
  localparam logic [3:0] CMP_MODE [5] = '{MODE_CMP_TOG, MODE_CMP_CLR, MODE_CMP_SET,
    MODE_CMP_SWI, MODE_CMP_SPEV};
  localparam logic [4:0] CMP_PIN = 5'h1D;
  logic clock_in = 1'b0, srst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, q;
  logic pready, pslverr, sleep_in = 1'b0, pin_main_out, pin_main_oe_out, pin_alt_out;
  logic pin_alt_oe_out, unit_irq_out, special_trigger_out, m_main, m_alt, e;
  wire logic ext_tmr_clk_in, pin_main_in, pin_alt_in;
  int n_fail = 0, n_tests = 0, n_trig = 0, n;
  assign pin_main_in = pin_main_oe_out ? pin_main_out : m_main;
  assign pin_alt_in = pin_alt_oe_out ? pin_alt_out : m_alt;
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) if (special_trigger_out === 1'b1) n_trig <= n_trig + 1;
  tccu_top #(.TMR_W(TMR_W)) dut (.clock_in, .srst_in, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .sleep_in, .ext_tmr_clk_in, .pin_main_in,
    .pin_main_out, .pin_main_oe_out, .pin_alt_in, .pin_alt_out, .pin_alt_oe_out,
    .unit_irq_out, .special_trigger_out);
  tccu_pin_model pm (.clock_in, .main_out(m_main), .alt_out(m_alt),
    .ext_clk_out(ext_tmr_clk_in));
  // --
  // tasks
  // --
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, d, x, y);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 8'h00, x, y);
    chk(x, {24'h0, exp});
  endtask
  // off first, then the new setting, then drop any false flag
  task automatic mode(input logic [3:0] m);
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_CONTROL, {4'h0, m});
    wr(OFS_INT_FLAGS, 8'h00);
  endtask
  // --
  // sequence
  // --
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge clock_in);
    srst_in <= 1'b0;
    foreach (OFS[i]) rdc(OFS[i], 8'h00);
    apb(1'b0, 8'h24, 8'h00, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(OFS_TMR_LOW, 8'h34);
    wr(OFS_TMR_HIGH, 8'h12);
    mode(MODE_CAP_RISE);
    pm.pulses(1'b0, 1);
    rdc(OFS_CC_LOW, 8'h34);
    rdc(OFS_CC_HIGH, 8'h12);
    rdc(OFS_INT_FLAGS, 8'h04);
    chk({31'h0, unit_irq_out}, 32'h0);
    wr(OFS_TMR_LOW, 8'h56);
    pm.pulses(1'b0, 1);
    rdc(OFS_CC_LOW, 8'h56);
    mode(MODE_CAP_FALL);
    pm.level(1'b0, 1'b1);
    rdc(OFS_INT_FLAGS, 8'h00);
    pm.level(1'b0, 1'b0);
    rdc(OFS_INT_FLAGS, 8'h04);
    for (int k = 0; k < 2; k++) begin
      n = k ? PRESC_16 : PRESC_4;
      mode(k ? MODE_CAP_16TH : MODE_CAP_4TH);
      pm.pulses(1'b0, n - 1);
      rdc(OFS_INT_FLAGS, 8'h00);
      pm.pulses(1'b0, 1);
      rdc(OFS_INT_FLAGS, 8'h04);
    end
    mode(MODE_CAP_4TH);
    pm.pulses(1'b0, 2);
    wr(OFS_CONTROL, {4'h0, MODE_CAP_16TH});
    wr(OFS_INT_FLAGS, 8'h00);
    pm.pulses(1'b0, PRESC_16 - 3);
    rdc(OFS_INT_FLAGS, 8'h00);
    pm.pulses(1'b0, 1);
    rdc(OFS_INT_FLAGS, 8'h04);
    mode(MODE_CAP_4TH);
    pm.pulses(1'b0, 2);
    mode(MODE_CAP_4TH);
    pm.pulses(1'b0, 2);
    rdc(OFS_INT_FLAGS, 8'h00);
    pm.pulses(1'b0, 2);
    rdc(OFS_INT_FLAGS, 8'h04);
    wr(OFS_ALT_PIN, 8'h01);
    mode(MODE_CAP_RISE);
    pm.pulses(1'b0, 1);
    rdc(OFS_INT_FLAGS, 8'h00);
    pm.pulses(1'b1, 1);
    rdc(OFS_INT_FLAGS, 8'h04);
    wr(OFS_ALT_PIN, 8'h00);
    wr(OFS_INT_EN, 8'h04);
    wr(OFS_TMR_HIGH, 8'h00);
    wr(OFS_CC_LOW, 8'h08);
    wr(OFS_CC_HIGH, 8'h00);
    for (int k = 0; k < 5; k++) begin
      wr(OFS_TMR_CTRL, 8'h00);
      wr(OFS_TMR_LOW, 8'h00);
      wr(OFS_CONTROL, {4'h0, CMP_MODE[k]});
      wr(OFS_INT_FLAGS, 8'h00);
      n = n_trig;
      wr(OFS_TMR_CTRL, 8'h01);
      for (int i = 0; i < 200 && unit_irq_out !== 1'b1; i++) @(posedge clock_in);
      repeat (2) @(posedge clock_in);
      chk({31'h0, pin_main_out}, {31'h0, CMP_PIN[k]});
      chk({31'h0, pin_main_oe_out}, {31'h0, k < 3});
      chk({31'h0, n_trig > n}, {31'h0, k == 4});
      rdc(OFS_INT_FLAGS, 8'h04);
    end
    wr(OFS_CONTROL, {4'h0, MODE_CMP_SET});
    wr(OFS_ALT_PIN, 8'h01);
    @(posedge clock_in);
    chk({30'h0, pin_alt_oe_out, pin_main_oe_out}, 32'h2);
    chk({31'h0, pin_alt_out}, 32'h1);
    wr(OFS_ALT_PIN, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    @(posedge clock_in);
    sleep_in <= 1'b1;
    apb(1'b0, OFS_TMR_LOW, 8'h00, r, e);
    repeat (40) @(posedge clock_in);
    rdc(OFS_TMR_LOW, r[7:0]);
    sleep_in <= 1'b0;
    repeat (40) @(posedge clock_in);
    apb(1'b0, OFS_TMR_LOW, 8'h00, q, e);
    // 41 awake edges at one tick per four: resumed, not restarted
    chk({31'h0, (8'(q[7:0] - r[7:0]) inside {8'h0A, 8'h0B})}, 32'h1);
    wr(OFS_TMR_CTRL, {SRC_SYS, 6'h01});
    apb(1'b0, OFS_TMR_LOW, 8'h00, r, e);
    apb(1'b0, OFS_TMR_LOW, 8'h00, q, e);
    chk({24'h0, 8'(q[7:0] - r[7:0])}, 32'h3);
    wr(OFS_TMR_CTRL, 8'h00);
    wr(OFS_TMR_LOW, 8'h00);
    wr(OFS_TMR_CTRL, {SRC_EXT, 6'h01});
    mode(MODE_CAP_RISE);
    @(posedge clock_in);
    sleep_in <= 1'b1;
    pm.ticks(5);
    rdc(OFS_TMR_LOW, 8'h05);
    pm.pulses(1'b0, 1);
    rdc(OFS_CC_LOW, 8'h05);
    final_report;
  end
endmodule
bind tccu_top tccu_asserts #(.TMR_W(TMR_W)) u_chk (.clock_in, .srst_in, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .sleep_in, .ext_tmr_clk_in,
  .pin_main_in, .pin_main_out, .pin_main_oe_out, .pin_alt_in, .pin_alt_out,
  .pin_alt_oe_out, .unit_irq_out, .special_trigger_out);
`default_nettype wire
